// ---- hdl/flash_regs_pkg.sv ----
// shared constants for the flash page, protect and timing registers
package flash_regs_pkg;
   // ****************************************
   // register map (byte addresses on the register port)
   // ****************************************
   localparam int addr_width = 12;
   localparam logic [11:0] page_select_addr = 12'hff9;
   localparam logic [11:0] sector_protect_addr = 12'hff9;
   localparam logic [11:0] program_clock_khz_high_addr = 12'hffa;
   localparam logic [11:0] program_clock_khz_low_addr = 12'hffb;
   localparam logic [11:0] flash_control_addr = 12'hff8;
   localparam logic [7:0] protect_unlock_code = 8'h5e;
   localparam logic [7:0] reg_reset = 8'h00;
   // ****************************************
   // field layout and flash geometry
   // ****************************************
   localparam int info_area_select_bit = 7;
   localparam int page_msb = 6;
   localparam int page_bytes = 512;
   localparam int page_shift = 9;
   localparam int sector_count = 8;
   localparam int sector_bits = 3;
   localparam logic [15:0] info_area_base = 16'hfe00;
   localparam int default_sector_bytes = 8192;
   // ****************************************
   // types
   // ****************************************
   typedef logic [addr_width-1:0] reg_addr_t;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] flash_addr_t;
endpackage

// ---- hdl/sector_check_if.sv ----
// bundle between the request path and the sector lookup
`timescale 1ns/1ps
interface sector_check_if;
   import flash_regs_pkg::*;
   flash_addr_t target_addr;
   logic [sector_count-1:0] sector_lock_bit;
   logic [sector_bits-1:0] sector;
   logic locked;
   modport requester (output target_addr, output sector_lock_bit,
                      input sector, input locked);
   modport checker_side (input target_addr, input sector_lock_bit,
                         output sector, output locked);
endinterface

// ---- hdl/sector_lookup.sv ----
// decodes the target sector and whether it is locked
`timescale 1ns/1ps
module sector_lookup #(
   parameter int sector_bytes = flash_regs_pkg::default_sector_bytes
) (
   sector_check_if.checker_side chk
);
   import flash_regs_pkg::*;
   localparam int sector_shift = $clog2(sector_bytes);

   // ****************************************
   // elaboration check
   // ****************************************
   if (sector_bytes != 2048 && sector_bytes != 4096 &&
       sector_bytes != 8192) begin : g_bad_size
      $error("sector_bytes must be 2048, 4096 or 8192");
   end

   // ****************************************
   // lookup
   // ****************************************
   // sectors sit on size-aligned boundaries, so a shift picks the index
   always_comb begin
      chk.sector = chk.target_addr[sector_shift +: sector_bits]; // see (RL12)
      chk.locked = chk.sector_lock_bit[chk.sector]; // see (RL2)
   end
endmodule

// ---- hdl/khz_tick.sv ----
// one-cycle tick every millisecond, scaled from the clock-in-khz value
`timescale 1ns/1ps
module khz_tick (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [15:0] program_clock_khz,
   output logic tick
);
   import flash_regs_pkg::*;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic tick_reg;
   logic tick_next;

   // ****************************************
   // divider
   // ****************************************
   // clock cycles per millisecond equal the khz figure itself
   always_comb begin
      count_next = count_reg + 16'h0001;
      tick_next = 1'b0;
      if (program_clock_khz == 16'h0000) begin
         count_next = 16'h0000; // no rate loaded: no timing base
      end else if (count_reg >= program_clock_khz - 16'h0001) begin
         count_next = 16'h0000;
         tick_next = 1'b1; // see (RL9)
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule

// ---- hdl/flash_page_protect_timing_regs.sv ----
// page select, sector protect and program-clock registers of the flash
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// (RL1) flash is organised in 512-byte pages, the smallest erasable unit
// (RL2) the array splits into 8 sectors, each protected on its own
// (RL3) 7-bit page number forms flash address bits 15 to 9
// (RL4) info select bit set maps info area onto FE00H-FFFFH
// (RL5) protect register shares FF9H, reachable only after control gets 5EH
// (RL6) user writes can only set protect bits; register stays readable
// (RL7) set lock bit rejects user program or erase in that sector
// (RL8) debug channel requests pass regardless of sector protection
// (RL9) FFAH high and FFBH low bytes form 16-bit clock-in-khz value
// (RL10) software loads that value with clock in hertz over 1000
// (RL11) software avoids program or erase below 20kHz or above 20MHz
// (RL12) target sector decoded from upper address by 2K, 4K or 8K size
// (RL13) all four registers clear to zero on reset
module flash_page_protect_timing_regs #(
   parameter int sector_bytes = flash_regs_pkg::default_sector_bytes
) (
   input wire logic clock,
   input wire logic resetn,
   input wire flash_regs_pkg::reg_addr_t reg_addr,
   input wire flash_regs_pkg::byte_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output flash_regs_pkg::byte_t reg_rdata,
   input wire flash_regs_pkg::flash_addr_t fetch_addr,
   output logic info_area_hit,
   input wire logic op_request,
   input wire logic op_from_debug,
   input wire logic op_page_erase,
   input wire flash_regs_pkg::flash_addr_t op_program_addr,
   output logic op_accept,
   output logic op_reject,
   output flash_regs_pkg::flash_addr_t op_target_addr,
   output logic op_is_erase,
   output logic [15:0] program_clock_khz,
   output logic ms_tick,
   output logic protect_unlocked
);
   import flash_regs_pkg::*;

   byte_t page_select_reg;
   byte_t page_select_next;
   byte_t sector_protect_reg;
   byte_t sector_protect_next;
   byte_t clk_high_reg;
   byte_t clk_high_next;
   byte_t clk_low_reg;
   byte_t clk_low_next;
   logic unlock_reg;
   logic unlock_next;
   byte_t rdata_reg;
   byte_t rdata_next;
   logic info_hit_reg;
   logic info_hit_next;
   logic accept_reg;
   logic accept_next;
   logic reject_reg;
   logic reject_next;
   flash_addr_t target_reg;
   flash_addr_t target_next;
   logic erase_reg;
   logic erase_next;
   logic tick_w;
   logic [15:0] khz_w;
   flash_addr_t request_addr;

   sector_check_if chk_bus ();

   // ****************************************
   // elaboration check
   // ****************************************
   if (page_bytes != (1 << page_shift)) begin : g_bad_page
      $error("page size and page shift disagree");
   end

   // ****************************************
   // register writes
   // ****************************************
   always_comb begin
      page_select_next = page_select_reg;
      sector_protect_next = sector_protect_reg;
      clk_high_next = clk_high_reg;
      clk_low_next = clk_low_reg;
      unlock_next = unlock_reg;
      if (reg_write) begin
         unique case (reg_addr)
            flash_control_addr: begin
               // unlock lasts until the control register sees another code
               unlock_next = (reg_wdata == protect_unlock_code); // see (RL5)
            end
            page_select_addr: begin
               if (unlock_reg) begin
                  // ones only accumulate: a zero never clears a lock
                  sector_protect_next = sector_protect_reg | reg_wdata; // see (RL6)
               end else begin
                  page_select_next = reg_wdata; // see (RL5)
               end
            end
            program_clock_khz_high_addr: begin
               clk_high_next = reg_wdata; // see (RL9)
            end
            program_clock_khz_low_addr: begin
               clk_low_next = reg_wdata; // see (RL9)
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   always_comb begin
      rdata_next = reg_reset;
      if (reg_read) begin
         unique case (reg_addr)
            page_select_addr: begin
               rdata_next = unlock_reg ? sector_protect_reg // see (RL6)
                                       : page_select_reg; // see (RL5)
            end
            program_clock_khz_high_addr: begin
               rdata_next = clk_high_reg;
            end
            program_clock_khz_low_addr: begin
               rdata_next = clk_low_reg;
            end
            default: begin
               rdata_next = reg_reset; // unmapped and control read as zero
            end
         endcase
      end
   end

   // ****************************************
   // information area mapping
   // ****************************************
   always_comb begin
      info_hit_next = page_select_reg[info_area_select_bit] &&
                      (fetch_addr >= info_area_base); // see (RL4)
   end

   // ****************************************
   // program and erase screening
   // ****************************************
   // page erase targets the selected page; program uses its own address
   always_comb begin
      request_addr = op_program_addr;
      if (op_page_erase) begin
         request_addr = {page_select_reg[page_msb:0],
                         {page_shift{1'b0}}}; // see (RL3) (RL1)
      end
   end

   assign chk_bus.target_addr = request_addr;
   assign chk_bus.sector_lock_bit = sector_protect_reg;

   sector_lookup #(
      .sector_bytes(sector_bytes)
   ) u_sector_lookup (
      .chk(chk_bus)
   );

   always_comb begin
      accept_next = 1'b0;
      reject_next = 1'b0;
      target_next = target_reg;
      erase_next = erase_reg;
      if (op_request) begin
         target_next = request_addr;
         erase_next = op_page_erase;
         // debug channel bypasses the locks
         if (!op_from_debug && chk_bus.locked) begin // see (RL8)
            reject_next = 1'b1; // see (RL7)
         end else begin
            accept_next = 1'b1; // see (RL7)
         end
      end
   end

   // ****************************************
   // timing base
   // ****************************************
   assign khz_w = {clk_high_reg, clk_low_reg}; // see (RL9)

   khz_tick u_khz_tick (
      .clock(clock),
      .resetn(resetn),
      .program_clock_khz(khz_w),
      .tick(tick_w)
   );

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         page_select_reg <= reg_reset; // see (RL13)
         sector_protect_reg <= reg_reset; // see (RL13)
         clk_high_reg <= reg_reset; // see (RL13)
         clk_low_reg <= reg_reset; // see (RL13)
         unlock_reg <= 1'b0;
         rdata_reg <= reg_reset;
         info_hit_reg <= 1'b0;
         accept_reg <= 1'b0;
         reject_reg <= 1'b0;
         target_reg <= 16'h0000;
         erase_reg <= 1'b0;
      end else begin
         page_select_reg <= page_select_next;
         sector_protect_reg <= sector_protect_next;
         clk_high_reg <= clk_high_next;
         clk_low_reg <= clk_low_next;
         unlock_reg <= unlock_next;
         rdata_reg <= rdata_next;
         info_hit_reg <= info_hit_next;
         accept_reg <= accept_next;
         reject_reg <= reject_next;
         target_reg <= target_next;
         erase_reg <= erase_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata = rdata_reg;
   assign info_area_hit = info_hit_reg;
   assign op_accept = accept_reg;
   assign op_reject = reject_reg;
   assign op_target_addr = target_reg;
   assign op_is_erase = erase_reg;
   assign program_clock_khz = khz_w;
   assign ms_tick = tick_w;
   assign protect_unlocked = unlock_reg;
endmodule

// ---- dv/flash_page_protect_timing_regs_sva.sv ----
// assertions on the flash page, protect and clock-in-khz register block
`timescale 1ns/1ps
module flash_regs_checker (
   input wire logic clock,
   input wire logic resetn,
   input wire flash_regs_pkg::reg_addr_t reg_addr,
   input wire flash_regs_pkg::byte_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire flash_regs_pkg::byte_t reg_rdata,
   input wire flash_regs_pkg::flash_addr_t fetch_addr,
   input wire logic info_area_hit,
   input wire logic op_request,
   input wire logic op_from_debug,
   input wire logic op_page_erase,
   input wire flash_regs_pkg::flash_addr_t op_program_addr,
   input wire logic op_accept,
   input wire logic op_reject,
   input wire flash_regs_pkg::flash_addr_t op_target_addr,
   input wire logic op_is_erase,
   input wire logic [15:0] program_clock_khz,
   input wire logic ms_tick,
   input wire logic protect_unlocked
);
   import flash_regs_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // ****************************************
   // assertions
   // ****************************************
   a_read_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_unlock_code: assert property (reg_write &&
      reg_addr == 12'hff8 |=>
      protect_unlocked == ($past(reg_wdata) == 8'h5e))
      else $error("unlock does not follow control write");
   a_debug_pass: assert property (op_request &&
      op_from_debug |=> op_accept && !op_reject)
      else $error("debug request not accepted");
   a_one_answer: assert property (op_request |=>
      op_accept != op_reject)
      else $error("request needs exactly one answer");
   a_no_request: assert property (!op_request |=> !op_accept && !op_reject)
      else $error("answer without request");
   a_erase_page: assert property (op_request &&
      op_page_erase |=> op_is_erase && op_target_addr[8:0] == 9'h000)
      else $error("erase target not page aligned");
   a_prog_target: assert property (op_request && !op_page_erase |=>
      !op_is_erase && op_target_addr == $past(op_program_addr))
      else $error("program target wrong");
   a_target_holds: assert property (!op_request |=>
      $stable(op_target_addr) && $stable(op_is_erase))
      else $error("target changed without request");
   a_khz_high: assert property (reg_write &&
      reg_addr == 12'hffa |=> program_clock_khz[15:8] == $past(reg_wdata))
      else $error("high byte not in upper half");
   // a zero value must keep the tick silent, else timing runs wild
   a_tick_zero: assert property (program_clock_khz == 16'h0000 &&
      $past(program_clock_khz) == 16'h0000 |-> !ms_tick)
      else $error("tick with zero frequency");
   a_info_map: assert property (info_area_hit |->
      $past(fetch_addr) >= 16'hfe00)
      else $error("info hit outside top page");
   c_reject: cover property (op_reject);
   c_debug: cover property (op_request && op_from_debug ##1 op_accept);
   c_tick: cover property (ms_tick ##5 ms_tick);
endmodule
bind flash_page_protect_timing_regs flash_regs_checker chk (
   .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .fetch_addr(fetch_addr),
   .info_area_hit(info_area_hit), .op_request(op_request),
   .op_from_debug(op_from_debug), .op_page_erase(op_page_erase),
   .op_program_addr(op_program_addr), .op_accept(op_accept),
   .op_reject(op_reject), .op_target_addr(op_target_addr),
   .op_is_erase(op_is_erase), .program_clock_khz(program_clock_khz),
   .ms_tick(ms_tick), .protect_unlocked(protect_unlocked));

// ---- dv/tb.sv ----
// self-checking bench for the flash page, protect and clock registers
`timescale 1ns/1ps
module tb;
   import flash_regs_pkg::*;
   logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0;
   logic op_request = 0, op_from_debug = 0, op_page_erase = 0;
   logic info_area_hit, op_accept, op_reject, op_is_erase, ms_tick, unl;
   reg_addr_t reg_addr = 12'h000;
   byte_t reg_wdata = 8'h00, reg_rdata;
   flash_addr_t fetch_addr = 16'h0000, op_program_addr = 16'h0000, tgt;
   logic [15:0] khz;
   int errors = 0, checks_done = 0;
   always #2.5 clock = ~clock;
   flash_page_protect_timing_regs #(.sector_bytes(8192)) dut (
      .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .fetch_addr(fetch_addr),
      .info_area_hit(info_area_hit), .op_request(op_request),
      .op_from_debug(op_from_debug), .op_page_erase(op_page_erase),
      .op_program_addr(op_program_addr), .op_accept(op_accept),
      .op_reject(op_reject), .op_target_addr(tgt), .op_is_erase(op_is_erase),
      .program_clock_khz(khz), .ms_tick(ms_tick), .protect_unlocked(unl));
   // ****************************************
   // shared tasks
   // ****************************************
   task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input reg_addr_t a, input byte_t d);
      @(posedge clock);
      reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask
   task rd(input reg_addr_t a, input byte_t e);
      @(posedge clock);
      reg_addr <= a; reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 cmp("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
   endtask
   // page register holds 7f in every request below, so erase hits fe00
   task op(input flash_addr_t a, input logic er, dbg, acc);
      @(posedge clock);
      op_request <= 1'b1; op_program_addr <= a;
      op_page_erase <= er; op_from_debug <= dbg;
      @(posedge clock);
      op_request <= 1'b0;
      #1 cmp("op_accept", {15'h0, acc}, {15'h0, op_accept});
      cmp("op_reject", {15'h0, !acc}, {15'h0, op_reject});
      cmp("op_target_addr", er ? 16'hfe00 : a, tgt);
   endtask
   task fetch(input flash_addr_t a, input logic e);
      @(posedge clock);
      fetch_addr <= a;
      @(posedge clock);
      #1 cmp("info_area_hit", {15'h0, e}, {15'h0, info_area_hit});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task test_reset;
      rd(12'hff9, 8'h00);
      rd(12'hffa, 8'h00);
      rd(12'hffb, 8'h00);
      rd(12'hff0, 8'h00);
      $display("test reset done");
   endtask
   task test_page;
      wr(12'hff9, 8'hff);
      fetch(16'hfe00, 1'b1);
      fetch(16'hfdff, 1'b0);
      wr(12'hff9, 8'h7f);
      fetch(16'hffff, 1'b0);
      rd(12'hff9, 8'h7f);
      $display("test page done");
   endtask
   task test_protect;
      wr(12'hff8, 8'h5e);
      cmp("protect_unlocked", 16'h1, {15'h0, unl});
      wr(12'hff9, 8'h05);
      wr(12'hff9, 8'h00);
      rd(12'hff9, 8'h05);
      wr(12'hff8, 8'h00);
      rd(12'hff9, 8'h7f);
      $display("test protect done");
   endtask
   task test_ops;
      // a supported rate goes in before the first program or erase
      wr(12'hffa, 8'h27);
      wr(12'hffb, 8'h10);
      cmp("program_clock_khz", 16'h2710, khz);
      op(16'h1ffe, 1'b0, 1'b0, 1'b0);
      op(16'h2000, 1'b0, 1'b0, 1'b1);
      op(16'h3fff, 1'b0, 1'b0, 1'b1);
      op(16'h4000, 1'b0, 1'b0, 1'b0);
      op(16'h0000, 1'b0, 1'b1, 1'b1);
      op(16'h0000, 1'b1, 1'b0, 1'b1);
      cmp("op_is_erase", 16'h1, {15'h0, op_is_erase});
      $display("test ops done");
   endtask
   task test_clock;
      int n;
      wr(12'hffa, 8'h12);
      wr(12'hffb, 8'h34);
      cmp("program_clock_khz", 16'h1234, khz);
      wr(12'hffa, 8'h00);
      wr(12'hffb, 8'h05);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clock);
            #1 n++;
         end while (ms_tick !== 1'b1 && n < 50);
      end
      cmp("tick period", 16'd5, 16'(n));
      $display("test clock done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      test_reset;
      test_page;
      test_protect;
      test_ops;
      test_clock;
      results;
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      errors++;
      results;
   end
endmodule
